// ---- dv/banked_data_memory_indirect_access_tb.sv ----
// self-checking bench for the banked data memory
`timescale 1ns/1ns
module banked_data_memory_indirect_access_tb import bdm_pkg::*;;
  logic ref_clk_in, rst_n_in, psel, pen, pwr, rdy, serr, er, ok;
  logic [11:0] padr;
  logic [31:0] pwd, prd, rd;
  logic [7:0] a, d, v;
  logic [2:0] b;
  int fail_count, n_compared;
  logic rdy_s, serr_s;
  logic [31:0] prd_s, rd_s;
  bdm_cpu_model i_bdm_cpu_model (.ref_clk_in(ref_clk_in), .psel_out(psel), .penable_out(pen),
    .pwrite_out(pwr), .paddr_out(padr), .pwdata_out(pwd), .prdata_in(prd), .pready_in(rdy), .pslverr_in(serr));
  bdm_data_memory i_bdm_data_memory (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(serr));
  // smallest variant on the same bus, for the pointer bit 7 view
  bdm_data_memory #(.SIZE_SEL(BDM_SIZE_64)) i_bdm_data_memory_small (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
    .pwdata_in(pwd), .prdata_out(prd_s), .pready_out(rdy_s), .pslverr_out(serr_s));
  // keep the small variant's read data from its ready edge
  always @(posedge ref_clk_in) if (rdy_s && !pwr) rd_s <= prd_s;
  // 50 mhz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // a hang counts as a mismatch and ends the run
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    i_bdm_cpu_model.xfer(w, ad, wd, rd, er, ok);
    if (!ok) begin
      fail_count++;
      $display("BAD %0t bus hang", $time);
      final_report();
    end
  endtask : bus
  function automatic logic [31:0] cw(bdm_op_type op, logic [7:0] ad, logic [2:0] bi, logic [7:0] dt);
    return {9'h000, op, 1'b0, bi, ad, dt};
  endfunction : cw
  function automatic logic [31:0] bitop(logic [7:0] x, logic [2:0] bi, logic s);
    return {24'h0, s ? (x | (8'h01 << bi)) : (x & ~(8'h01 << bi))};
  endfunction : bitop
  task automatic op(bdm_op_type o, logic [7:0] ad, logic [2:0] bi, logic [7:0] dt);
    bus(1'b1, BDM_APB_CMD, cw(o, ad, bi, dt));
  endtask : op
  task automatic rb(input logic [7:0] ad);
    op(BDM_OP_READ, ad, 3'h0, 8'h00);
    bus(1'b0, BDM_APB_RDATA, 32'h0);
  endtask : rb
  task automatic do_reset();
    rst_n_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    bus(1'b0, BDM_APB_MP0, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, BDM_APB_MP1, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, BDM_APB_CFG, 32'h0);
    chk(rd, 32'h0);
  endtask : do_reset
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(99));
    do_reset();
    // random general storage traffic plus bit operations on each byte
    for (int i = 0; i < 8; i++) begin
      a = 8'h40 + 8'($urandom % 64);
      d = 8'($urandom);
      b = 3'($urandom);
      op(BDM_OP_WRITE, a, 3'h0, d);
      rb(a);
      chk(rd, {24'h0, d});
      op(BDM_OP_SET, a, b, 8'h00);
      rb(a);
      chk(rd, bitop(d, b, 1'b1));
      v = 8'(bitop(d, b, 1'b1));
      op(BDM_OP_CLR, a, b, 8'h00);
      rb(a);
      chk(rd, bitop(v, b, 1'b0));
    end
    // dedicated bit in the special area refuses a set
    op(BDM_OP_WRITE, 8'h10, 3'h0, 8'h00);
    op(BDM_OP_SET, 8'h10, 3'h7, 8'h00);
    rb(8'h10);
    chk(rd, 32'h0);
    // pointer 0 as a real register and its port redirect
    op(BDM_OP_WRITE, BDM_ADDR_MP0, 3'h0, 8'h50);
    bus(1'b0, BDM_APB_MP0, 32'h0);
    chk(rd, 32'h50);
    op(BDM_OP_WRITE, BDM_ADDR_PORT0, 3'h0, 8'ha5);
    chk(rd_s, {24'h0, 8'h50 | BDM_BIT7});
    rb(8'h50);
    chk(rd, 32'ha5);
    rb(BDM_ADDR_PORT0);
    chk(rd, 32'ha5);
    // pointer aimed at a port reads zero
    op(BDM_OP_WRITE, BDM_ADDR_MP0, 3'h0, BDM_ADDR_PORT1);
    op(BDM_OP_WRITE, BDM_ADDR_PORT0, 3'h0, 8'h5a);
    rb(BDM_ADDR_PORT0);
    chk(rd, 32'h0);
    // reserved gap stays zero even after a write
    op(BDM_OP_WRITE, 8'h30, 3'h0, 8'hff);
    rb(8'h30);
    chk(rd, 32'h0);
    // bank 1 through pointer 1 only, special area shared
    op(BDM_OP_WRITE, 8'h60, 3'h0, 8'h11);
    bus(1'b1, BDM_APB_CFG, 32'h1);
    op(BDM_OP_WRITE, BDM_ADDR_MP1, 3'h0, 8'h60);
    op(BDM_OP_WRITE, BDM_ADDR_PORT1, 3'h0, 8'h22);
    rb(BDM_ADDR_PORT1);
    chk(rd, 32'h22);
    rb(8'h60);
    chk(rd, 32'h11);
    op(BDM_OP_WRITE, BDM_ADDR_MP1, 3'h0, 8'h12);
    op(BDM_OP_WRITE, BDM_ADDR_PORT1, 3'h0, 8'h33);
    rb(8'h12);
    chk(rd, 32'h33);
    // unmapped register address is refused
    bus(1'b1, 12'h014, 32'h1);
    chk({31'h0, er}, 32'h1);
    // mid-run reset clears the pointers
    do_reset();
    final_report();
  end
endmodule : banked_data_memory_indirect_access_tb

// ---- dv/bdm_cpu_model.sv ----
// apb master standing in for the cpu datapath at the far side
`timescale 1ns/1ns
module bdm_cpu_model (
  // clock
  input wire logic ref_clk_in,
  // apb master side
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  // idle bus from time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // one transfer; the request stands until pready is sampled high at a rising edge or 16 edges pass, released at that edge
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    rdat = 32'h0000_0000;
    err = 1'b0;
    @(posedge ref_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= adr;
    pwdata_out <= wd;
    @(posedge ref_clk_in);
    penable_out <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge ref_clk_in);
      ok = (pready_in === 1'b1);
    end
    rdat = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask : xfer
endmodule : bdm_cpu_model

// ---- logic/bdm_data_memory.sv ----
// banked byte data memory with indirect access, apb command front end
`timescale 1ns/1ns
module bdm_data_memory
  import bdm_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = BDM_SIZE_128
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // both banks are sized for the largest variant; smaller variants leave the top unused
  localparam int DEPTH = 128;
  logic [7:0] gp_mem [0:DEPTH-1]; // bank 0 storage
  logic [7:0] gp_mem1 [0:DEPTH-1]; // bank 1 storage
  logic [7:0] mp0;
  logic [7:0] mp1;
  logic [7:0] rdata;
  logic bank_sel;

  // capacity limit from variant
  function automatic logic [7:0] top_addr(input logic [1:0] sz);
    case (sz)
      BDM_SIZE_64: top_addr = 8'h40;
      BDM_SIZE_96: top_addr = 8'h60;
      default: top_addr = 8'h80;
    endcase
  endfunction : top_addr

  // pointer read view, bit 7 forced on smallest variant
  function automatic logic [7:0] ptr_view(input logic [7:0] p);
    ptr_view = (SIZE_SEL == BDM_SIZE_64) ? (p | BDM_BIT7) : p;
  endfunction : ptr_view

  // is an address backed by a storage byte
  function automatic logic is_store(input logic [7:0] a);
    is_store = (a < top_addr(SIZE_SEL)) && (a >= BDM_GP_START || (a > BDM_ADDR_MP1 && a < BDM_SFR_END));
  endfunction : is_store

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic acc;
  logic cmd_wr;
  bdm_op_type op;
  logic [7:0] d_addr;
  logic [7:0] d_data;
  logic [2:0] d_bit;
  // act only at the ready edge, so a stalled access phase never repeats a command
  assign acc = psel_in && penable_in && pready_out;
  assign cmd_wr = acc && pwrite_in && paddr_in == BDM_APB_CMD;
  assign op = bdm_op_type'(pwdata_in[BDM_CMD_OP_LSB +: 3]);
  assign d_addr = pwdata_in[BDM_CMD_ADDR_LSB +: 8] & 8'h7f;
  assign d_data = pwdata_in[BDM_CMD_DATA_LSB +: 8];
  assign d_bit = pwdata_in[BDM_CMD_BIT_LSB +: 3];

  // resolve port accesses through pointers
  // pointer bit 7 never reaches the address, so both pointers see the same seven-bit space
  logic [7:0] eff_addr;
  logic eff_bank;
  logic eff_null;
  always_comb begin
    eff_addr = d_addr;
    eff_bank = 1'b0; // direct goes to bank 0
    eff_null = 1'b0;
    if (d_addr == BDM_ADDR_PORT0) begin
      eff_addr = mp0 & 8'h7f;
      eff_null = eff_addr == BDM_ADDR_PORT0 || eff_addr == BDM_ADDR_PORT1;
    end else if (d_addr == BDM_ADDR_PORT1) begin
      eff_addr = mp1 & 8'h7f;
      eff_bank = bank_sel;
      eff_null = eff_addr == BDM_ADDR_PORT0 || eff_addr == BDM_ADDR_PORT1;
    end
  end

  // shared special area, banked general area
  logic use_b1;
  assign use_b1 = eff_bank && eff_addr >= BDM_GP_START;

  // current byte at the effective location
  logic [7:0] cur;
  always_comb begin
    cur = BDM_ZERO;
    if (eff_null) cur = BDM_ZERO;
    else if (eff_addr == BDM_ADDR_MP0) cur = ptr_view(mp0);
    else if (eff_addr == BDM_ADDR_MP1) cur = ptr_view(mp1);
    else if (is_store(eff_addr)) cur = use_b1 ? gp_mem1[eff_addr[6:0]] : gp_mem[eff_addr[6:0]];
  end

  // modified byte for write and bit ops
  logic [7:0] nval;
  logic do_wr;
  always_comb begin
    nval = cur;
    do_wr = cmd_wr && !eff_null && eff_addr != BDM_ADDR_RO;
    case (op)
      BDM_OP_WRITE: nval = d_data;
      BDM_OP_SET: nval = cur | (8'h01 << d_bit);
      BDM_OP_CLR: nval = cur & ~(8'h01 << d_bit);
      default: do_wr = 1'b0;
    endcase
    // dedicated bit of special area is excluded from bit ops
    if ((op == BDM_OP_SET || op == BDM_OP_CLR) && eff_addr < BDM_GP_START && d_bit == 3'(BDM_PROT_BIT))
      do_wr = 1'b0;
  end

  // ----------------------------------------------------------------------
  // state updates
  // ----------------------------------------------------------------------
  // pointers, cleared by reset
  // a pointer aimed at itself through its port is written like any other location
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mp0 <= BDM_ZERO;
      mp1 <= BDM_ZERO;
    end else if (do_wr && eff_addr == BDM_ADDR_MP0) begin
      mp0 <= nval;
    end else if (do_wr && eff_addr == BDM_ADDR_MP1) begin
      mp1 <= nval;
    end
  end

  // byte storage; no reset so it maps to ram
  // special bytes always live in bank 0 storage, which keeps them common to both banks
  always_ff @(posedge ref_clk_in) begin
    if (do_wr && is_store(eff_addr)) begin
      if (use_b1) gp_mem1[eff_addr[6:0]] <= nval;
      else gp_mem[eff_addr[6:0]] <= nval;
    end
  end

  // read result and bank select
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= BDM_ZERO;
      bank_sel <= 1'b0;
    end else begin
      if (cmd_wr && op == BDM_OP_READ) rdata <= cur;
      if (acc && pwrite_in && paddr_in == BDM_APB_CFG) bank_sel <= pwdata_in[0];
    end
  end

  // apb answer: one wait state, reads registered
  // error and data only travel with the ready pulse, both zero otherwise
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        case (paddr_in)
          BDM_APB_RDATA: prdata_out <= {24'h000000, rdata};
          BDM_APB_MP0: prdata_out <= {24'h000000, ptr_view(mp0)};
          BDM_APB_MP1: prdata_out <= {24'h000000, ptr_view(mp1)};
          BDM_APB_CFG: prdata_out <= {31'h00000000, bank_sel};
          BDM_APB_CMD: prdata_out <= 32'h0000_0000;
          default: pslverr_out <= 1'b1;
        endcase
      end else if (psel_in && penable_in && !pready_out) begin
        pslverr_out <= !(paddr_in == BDM_APB_CMD || paddr_in == BDM_APB_CFG);
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // last stored byte, kept one clock so a check can read it back
  logic chk_wr_seen;
  logic chk_wr_bank;
  logic [6:0] chk_wr_idx;
  logic [7:0] chk_wr_val;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_wr_seen <= 1'b0;
      chk_wr_bank <= 1'b0;
      chk_wr_idx <= 7'h00;
      chk_wr_val <= BDM_ZERO;
    end else begin
      chk_wr_seen <= do_wr && is_store(eff_addr);
      chk_wr_bank <= use_b1;
      chk_wr_idx <= eff_addr[6:0];
      chk_wr_val <= nval;
    end
  end
  // byte now held at the last written slot
  logic [7:0] chk_rd_back;
  assign chk_rd_back = chk_wr_bank ? gp_mem1[chk_wr_idx] : gp_mem[chk_wr_idx];

  // reset and pointer registers
  a_ptr_reset_zero: assert property (@(posedge ref_clk_in)
    $rose(rst_n_in) |-> mp0 == BDM_ZERO && mp1 == BDM_ZERO && !bank_sel)
    else $error("pointers not cleared by reset");
  a_ptr_bit7_one: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    SIZE_SEL == BDM_SIZE_64 |-> (ptr_view(mp0) & ptr_view(mp1) & BDM_BIT7) == BDM_BIT7)
    else $error("pointer bit 7 not read as one");
  a_ptr_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && op == BDM_OP_WRITE && d_addr == BDM_ADDR_MP0 |=> mp0 == $past(d_data))
    else $error("pointer 0 write lost");
  a_mp1_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && op == BDM_OP_WRITE && d_addr == BDM_ADDR_MP1 |=> mp1 == $past(d_data))
    else $error("pointer 1 write lost");
  a_ptr_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(do_wr && eff_addr == BDM_ADDR_MP0) |=> $stable(mp0))
    else $error("pointer 0 changed without a write");

  // indirect path and banks
  a_null_no_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    eff_null |-> !do_wr)
    else $error("write through self-aimed pointer");
  a_null_reads_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && op == BDM_OP_READ && eff_null |=> rdata == BDM_ZERO)
    else $error("self-aimed pointer read not zero");
  a_port_not_stored: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    do_wr |-> eff_addr != BDM_ADDR_PORT0 && eff_addr != BDM_ADDR_PORT1)
    else $error("port location itself written");
  a_port1_redirect: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && d_addr == BDM_ADDR_PORT1 |-> eff_addr == (mp1 & ~BDM_BIT7))
    else $error("port 1 not redirected through pointer 1");
  a_mp0_bank0: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    d_addr != BDM_ADDR_PORT1 |-> !eff_bank)
    else $error("bank 1 reached without pointer 1");
  a_mp0_low_bank: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    d_addr == BDM_ADDR_PORT0 |-> !use_b1)
    else $error("pointer 0 reached bank 1");
  a_bank_sel_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(acc && pwrite_in && paddr_in == BDM_APB_CFG) |=> $stable(bank_sel))
    else $error("bank select changed without a write");

  // storage, gaps and bit operations
  a_ro_kept: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    eff_addr == BDM_ADDR_RO |-> !do_wr)
    else $error("read-only location written");
  a_gap_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !eff_null && eff_addr >= BDM_SFR_END && eff_addr < BDM_GP_START |-> cur == BDM_ZERO)
    else $error("reserved gap not zero");
  a_beyond_top: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !eff_null && eff_addr >= top_addr(SIZE_SEL) |-> cur == BDM_ZERO)
    else $error("location above capacity not zero");
  a_bit7_guard: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && (op == BDM_OP_SET || op == BDM_OP_CLR) && eff_addr < BDM_GP_START
    && d_bit == 3'(BDM_PROT_BIT) |-> !do_wr)
    else $error("dedicated bit changed by a bit operation");
  a_gp_free: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && op == BDM_OP_WRITE && !eff_null && eff_addr >= BDM_GP_START
    && eff_addr < top_addr(SIZE_SEL) |-> do_wr)
    else $error("general storage write refused");
  a_wr_lands: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    chk_wr_seen |-> chk_rd_back == chk_wr_val)
    else $error("stored byte not found after write");
  a_read_capture: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    cmd_wr && op == BDM_OP_READ |=> rdata == $past(cur))
    else $error("read result not taken in one clock");

  // bus answer: a single ready pulse, data and error only with it
  a_apb_ready: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    psel_in && penable_in && !pready_out |=> pready_out)
    else $error("apb answer late");
  a_ready_pulse: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pready_out |=> !pready_out)
    else $error("ready held longer than one clock");
  a_idle_rdata: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data shown without ready");
  a_slverr_ready: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    pslverr_out |-> pready_out)
    else $error("error shown without ready");

  // main scenarios, to see that the bench reaches them
  c_indirect_wr: cover property (@(posedge ref_clk_in) cmd_wr && d_addr == BDM_ADDR_PORT1 && do_wr);
  c_bit_set: cover property (@(posedge ref_clk_in) cmd_wr && op == BDM_OP_SET && do_wr);
  c_bank1: cover property (@(posedge ref_clk_in) do_wr && use_b1);
  c_null_port: cover property (@(posedge ref_clk_in) cmd_wr && eff_null);
  c_bank1_read: cover property (@(posedge ref_clk_in) cmd_wr && op == BDM_OP_READ && use_b1);
endmodule : bdm_data_memory

// ---- logic/bdm_pkg.sv ----
// package of constants for the banked data memory
package bdm_pkg;
  // ----------------------------------------------------------------------
  // apb register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] BDM_APB_CMD = 12'h000; // command word
  localparam logic [11:0] BDM_APB_RDATA = 12'h004; // last read result
  localparam logic [11:0] BDM_APB_MP0 = 12'h008; // pointer 0 view
  localparam logic [11:0] BDM_APB_MP1 = 12'h00c; // pointer 1 view
  localparam logic [11:0] BDM_APB_CFG = 12'h010; // bank select
  // ----------------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------------
  localparam int BDM_CMD_DATA_LSB = 0;
  localparam int BDM_CMD_ADDR_LSB = 8;
  localparam int BDM_CMD_BIT_LSB = 16;
  localparam int BDM_CMD_OP_LSB = 20;
  // ----------------------------------------------------------------------
  // data memory map
  // ----------------------------------------------------------------------
  localparam logic [7:0] BDM_ADDR_PORT0 = 8'h00;
  localparam logic [7:0] BDM_ADDR_MP0 = 8'h01;
  localparam logic [7:0] BDM_ADDR_PORT1 = 8'h02;
  localparam logic [7:0] BDM_ADDR_MP1 = 8'h03;
  localparam logic [7:0] BDM_ADDR_RO = 8'h08; // read-only special location
  localparam logic [7:0] BDM_SFR_END = 8'h29; // first reserved location
  localparam logic [7:0] BDM_GP_START = 8'h40; // general storage start
  localparam logic [7:0] BDM_ZERO = 8'h00;
  localparam logic [7:0] BDM_BIT7 = 8'h80;
  localparam int BDM_PROT_BIT = 7; // dedicated bit, no bit ops in the special area
  localparam logic [1:0] BDM_SIZE_64 = 2'h0;
  localparam logic [1:0] BDM_SIZE_96 = 2'h1;
  localparam logic [1:0] BDM_SIZE_128 = 2'h2;
  // operation codes
  typedef enum logic [2:0] {
    BDM_OP_NONE = 3'h0, BDM_OP_READ = 3'h1, BDM_OP_WRITE = 3'h2, BDM_OP_SET = 3'h3, BDM_OP_CLR = 3'h4
  } bdm_op_type;
endpackage : bdm_pkg
